/* File: hdl/relay_pkg.sv */
package relay_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_WIDTH = 8'h04;
  localparam logic [7:0] OFS_WEIGHT = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  // ctrl fields
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_POL_BIT = 2;
  localparam int CTRL_SRC_LSB = 4;
  // cmd fields (write-one pulses)
  localparam int CMD_SET_BIT = 0;
  localparam int CMD_CLEAR_BIT = 1;
  localparam int CMD_PULSE_BIT = 2;
  // status fields
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_DRIVE_BIT = 1;
  localparam int STAT_BUSY_BIT = 2;
  localparam int STAT_PEND_LSB = 8;
  // pulse width in ms, and weight in tenths of an energy unit
  localparam int WIDTH_MIN_MS = 20;
  localparam int WIDTH_MAX_MS = 1000;
  localparam logic [9:0] WIDTH_RST_MS = 10'd100;
  localparam int WEIGHT_MIN_TENTHS = 1;
  localparam int WEIGHT_MAX_TENTHS = 10000;
  localparam logic [13:0] WEIGHT_RST_TENTHS = 14'h000A;
  localparam int MAINS_HZ_DEFAULT = 50;
  localparam int N_SOURCES = 6;

  typedef enum logic [1:0] {
    MODE_FOLLOW, MODE_HOLD, MODE_TIMED_PULSE, MODE_TRANSITION_PULSE
  } relay_mode_e;

  // 0 = none, 1..6 are the accumulators
  typedef enum logic [2:0] {
    SRC_NONE, ACTIVE_IMPORT_SOURCE, ACTIVE_EXPORT_SOURCE, REACTIVE_IMPORT_SOURCE,
    REACTIVE_EXPORT_SOURCE, REACTIVE_TOTAL_SOURCE, APPARENT_TOTAL_SOURCE
  } pulse_source_e;
endpackage

/* File: hdl/energy_weigher.sv */
// accumulates tenth-unit energy quanta and emits one pulse per weight
module energy_weigher
  import relay_pkg::*;
#(
  parameter int ACC_W = 15
) (
  input wire logic pclk, // clock
  input wire logic presetn, // async reset, active low
  input wire logic ce, // clock enable
  input wire logic quantum, // one tenth unit arrived
  input wire logic [13:0] weight, // tenths per pulse
  output logic pulse_q // one pulse per weight
);
  logic [ACC_W-1:0] acc_q;
  logic [13:0] wt;

  // a zero weight would pulse every quantum; clamp it to the least
  assign wt = (weight < 14'(WEIGHT_MIN_TENTHS)) ? 14'(WEIGHT_MIN_TENTHS) : weight;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
      pulse_q <= 1'b0;
    end else if (ce) begin
      pulse_q <= 1'b0;
      if (quantum) begin
        if (acc_q + 15'd1 >= {1'b0, wt}) begin
          acc_q <= '0;
          pulse_q <= 1'b1;
        end else begin
          acc_q <= acc_q + 15'd1;
        end
      end
    end
  end
endmodule

/* File: hdl/relay_output_pulser.sv */
module relay_output_pulser
  import relay_pkg::*;
#(
  parameter int MAINS_HZ = MAINS_HZ_DEFAULT,
  parameter int PEND_W = 8
) (
  input wire logic pclk, // 125 MHz clock
  input wire logic presetn, // async reset, active low
  input wire logic clk_en, // freezes all state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  input wire logic cycle_tick, // one pulse per mains cycle
  input wire logic setpoint_op, // control setpoint operated
  input wire logic [N_SOURCES-1:0] energy_quantum, // tenth-unit pulses per accumulator
  output logic relay_drive // relay coil energised
);
  logic [1:0] mode_q;
  logic pol_q;
  logic [2:0] src_q;
  logic [9:0] width_ms_q;
  logic [13:0] weight_q;
  logic active_q;
  logic sp_d1_q;
  logic busy_q;
  logic in_pause_q;
  logic [9:0] cyc_cnt_q;
  logic [PEND_W-1:0] pend_q;
  logic cmd_set, cmd_clear, cmd_pulse;
  logic wr_acc, rd_acc;
  logic quantum, energy_pulse;
  logic [9:0] width_cycles;
  logic sp_rise;
  logic issue;
  logic rdata_ok;
  logic [31:0] rdata;
  logic [19:0] prod;

  assign wr_acc = clk_en && psel && penable && pwrite;
  assign rd_acc = clk_en && psel && !penable && !pwrite;
  assign cmd_set = wr_acc && paddr == OFS_CMD && pwdata[CMD_SET_BIT];
  assign cmd_clear = wr_acc && paddr == OFS_CMD && pwdata[CMD_CLEAR_BIT];
  assign cmd_pulse = wr_acc && paddr == OFS_CMD && pwdata[CMD_PULSE_BIT];

  // pready is always high in access phase: zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
    end else if (clk_en) begin
      pready <= psel && !penable;
    end
  end

  // ---- configuration registers ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= MODE_FOLLOW;
      pol_q <= 1'b0;
      src_q <= SRC_NONE;
    end else if (wr_acc && paddr == OFS_CTRL) begin
      mode_q <= pwdata[CTRL_MODE_LSB +: 2];
      pol_q <= pwdata[CTRL_POL_BIT];
      // out-of-range codes fall back to no source
      src_q <= (pwdata[CTRL_SRC_LSB +: 3] > 3'(N_SOURCES)) ? 3'(SRC_NONE) : pwdata[CTRL_SRC_LSB +: 3];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      width_ms_q <= WIDTH_RST_MS;
    end else if (wr_acc && paddr == OFS_WIDTH) begin
      // clamp into the accepted range
      if (pwdata[15:0] < 16'(WIDTH_MIN_MS)) begin
        width_ms_q <= 10'(WIDTH_MIN_MS);
      end else if (pwdata[15:0] > 16'(WIDTH_MAX_MS)) begin
        width_ms_q <= 10'(WIDTH_MAX_MS);
      end else begin
        width_ms_q <= pwdata[9:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      weight_q <= WEIGHT_RST_TENTHS;
    end else if (wr_acc && paddr == OFS_WEIGHT) begin
      if (pwdata[15:0] < 16'(WEIGHT_MIN_TENTHS)) begin
        weight_q <= 14'(WEIGHT_MIN_TENTHS);
      end else if (pwdata[15:0] > 16'(WEIGHT_MAX_TENTHS)) begin
        weight_q <= 14'(WEIGHT_MAX_TENTHS);
      end else begin
        weight_q <= pwdata[13:0];
      end
    end
  end

  // ---- width in mains cycles, rounded up ----
  // cycles = ceil(ms * hz / 1000); combinational divide by constant is fine at 1 kHz-scale widths
  // widen both factors first: a 10-bit product would wrap above 1023
  assign prod = 20'(width_ms_q) * 20'(MAINS_HZ);
  assign width_cycles = 10'((prod + 20'd999) / 20'd1000);

  // ---- energy source ----
  // source only applies in the two pulse modes; others ignore it
  assign quantum = (src_q != SRC_NONE) && (mode_q == MODE_TIMED_PULSE || mode_q == MODE_TRANSITION_PULSE)
                   && energy_quantum[3'(src_q - 3'd1)];

  energy_weigher #(.ACC_W(15)) u_weigher (
    .pclk(pclk),
    .presetn(presetn),
    .ce(clk_en),
    .quantum(quantum),
    .weight(weight_q),
    .pulse_q(energy_pulse)
  );

  // ---- pending pulse queue ----
  // a pulse command or an energy pulse adds one, both in one cycle add only one; a saturated queue drops the excess
  assign issue = (pend_q != '0) && !busy_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= '0;
    end else if (clk_en) begin
      if (mode_q != MODE_TIMED_PULSE && mode_q != MODE_TRANSITION_PULSE) begin
        pend_q <= '0;
      end else begin
        case ({energy_pulse || cmd_pulse, issue})
          2'b10: pend_q <= (&pend_q) ? pend_q : pend_q + PEND_W'(1);
          2'b01: pend_q <= pend_q - PEND_W'(1);
          default: pend_q <= pend_q;
        endcase
      end
    end
  end

  // ---- pulse/pause timer ----
  // in transition mode the timer spaces toggles so the counter sees each state for the width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      in_pause_q <= 1'b0;
      cyc_cnt_q <= '0;
    end else if (clk_en) begin
      if (issue) begin
        busy_q <= 1'b1;
        in_pause_q <= 1'b0;
        cyc_cnt_q <= width_cycles;
      end else if (busy_q && cycle_tick) begin
        if (cyc_cnt_q > 10'd1) begin
          cyc_cnt_q <= cyc_cnt_q - 10'd1;
        end else if (!in_pause_q && mode_q == MODE_TIMED_PULSE) begin
          in_pause_q <= 1'b1;
          cyc_cnt_q <= width_cycles;
        end else begin
          busy_q <= 1'b0;
          in_pause_q <= 1'b0;
          cyc_cnt_q <= '0;
        end
      end
    end
  end

  // ---- relay active state ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sp_d1_q <= 1'b0;
    end else if (clk_en) begin
      sp_d1_q <= setpoint_op;
    end
  end
  assign sp_rise = setpoint_op && !sp_d1_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      active_q <= 1'b0;
    end else if (clk_en) begin
      case (relay_mode_e'(mode_q))
        MODE_FOLLOW: active_q <= setpoint_op || cmd_set;
        MODE_HOLD: begin
          if (sp_rise || cmd_set) begin
            active_q <= 1'b1;
          end else if (cmd_clear) begin
            active_q <= 1'b0;
          end
        end
        MODE_TIMED_PULSE: begin
          if (issue) begin
            active_q <= 1'b1;
          end else if (busy_q && cycle_tick && cyc_cnt_q <= 10'd1 && !in_pause_q) begin
            active_q <= 1'b0;
          end
        end
        MODE_TRANSITION_PULSE: begin
          if (issue) begin
            active_q <= !active_q;
          end
        end
        default: active_q <= 1'b0;
      endcase
    end
  end

  // ---- coil drive with polarity ----
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      relay_drive <= 1'b0;
    end else if (clk_en) begin
      relay_drive <= pol_q ? !active_q : active_q;
    end
  end

  // ---- read mux ----
  always_comb begin
    rdata = '0;
    rdata_ok = 1'b1;
    case (paddr)
      OFS_CTRL: begin
        rdata[CTRL_MODE_LSB +: 2] = mode_q;
        rdata[CTRL_POL_BIT] = pol_q;
        rdata[CTRL_SRC_LSB +: 3] = src_q;
      end
      OFS_WIDTH: rdata[9:0] = width_ms_q;
      OFS_WEIGHT: rdata[13:0] = weight_q;
      OFS_CMD: rdata = '0;
      OFS_STATUS: begin
        rdata[STAT_ACTIVE_BIT] = active_q;
        rdata[STAT_DRIVE_BIT] = relay_drive;
        rdata[STAT_BUSY_BIT] = busy_q;
        rdata[STAT_PEND_LSB +: PEND_W] = pend_q;
      end
      default: rdata_ok = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      if (psel && !penable) begin
        prdata <= rd_acc ? rdata : '0;
        pslverr <= !rdata_ok || (paddr[1:0] != 2'b00);
      end
    end
  end
endmodule

/* File: sim/relay_output_pulser_monitor.sv */
module relay_output_pulser_monitor
  import relay_pkg::*;
(
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic clk_en, // clock enable
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic relay_drive // coil drive
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic setup = psel && !penable && clk_en;
  wire logic rd_setup = setup && !pwrite;
  a_ready_access: assert property (setup |=> pready)
    else $error("no ready in access phase");
  a_ready_single: assert property (pready && clk_en |=> !pready)
    else $error("ready held past access");
  a_err_unmapped: assert property (setup && paddr > OFS_STATUS |=> pslverr)
    else $error("unmapped address not refused");
  a_err_unaligned: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned address not refused");
  a_ok_mapped: assert property (setup && paddr[1:0] == 2'h0 && paddr <= OFS_STATUS |=> !pslverr)
    else $error("mapped address refused");
  a_read_unmapped: assert property (rd_setup && paddr > OFS_STATUS |=> prdata == 32'h0)
    else $error("unmapped read not zero");
  a_cmd_reads_zero: assert property (rd_setup && paddr == OFS_CMD |=> prdata == 32'h0)
    else $error("command register read not zero");
  a_status_drive: assert property (rd_setup && paddr == OFS_STATUS |=>
    prdata[STAT_DRIVE_BIT] == $past(relay_drive))
    else $error("status drive bit differs from coil");
  a_data_stands: assert property (!(psel && !penable) && clk_en |=>
    $stable(prdata) && $stable(pslverr))
    else $error("read answer changed outside setup");
endmodule

bind relay_output_pulser relay_output_pulser_monitor relay_output_pulser_monitor_inst (
  .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .relay_drive(relay_drive));

/* File: sim/coil_model.sv */
// external pulse counter on the coil contact
module coil_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset, active low
  input wire logic cycle_tick, // mains tick
  input wire logic relay_drive, // coil energised
  output logic [7:0] n_pulse, // energised pulses seen
  output logic [7:0] hi_ticks, // ticks of last pulse
  output logic [7:0] gap_ticks // ticks of pause before it
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drive_q;
  logic tick_q;
  logic [7:0] lo_q;
  // tick delayed by one so it lines up with the drive lag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drive_q <= 1'b0;
      tick_q <= 1'b0;
      n_pulse <= 8'h00;
      hi_ticks <= 8'h00;
      gap_ticks <= 8'h00;
      lo_q <= 8'h00;
    end else begin
      drive_q <= relay_drive;
      tick_q <= cycle_tick;
      if (relay_drive && !drive_q) begin
        n_pulse <= n_pulse + 8'h01;
        gap_ticks <= lo_q;
        hi_ticks <= {7'h00, tick_q};
      end else if (relay_drive && tick_q) begin
        hi_ticks <= hi_ticks + 8'h01;
      end
      if (!relay_drive && drive_q) begin
        lo_q <= {7'h00, tick_q};
      end else if (!relay_drive && tick_q) begin
        lo_q <= lo_q + 8'h01;
      end
    end
  end
endmodule

/* File: sim/tb_relay_output_pulser.sv */
`define CHK(n, x, a) begin tests_run++; if ((a) !== (x)) begin n_mismatch++; \
  $display("[ERR] %s expected %0h seen %0h", n, x, a); end end
module tb_relay_output_pulser import relay_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic cycle_tick = 1'b0;
  logic setpoint_op = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [5:0] energy_quantum = 6'h00;
  logic [2:0] tcnt = 3'h0;
  wire logic [31:0] prdata;
  wire logic pready;
  wire logic pslverr;
  wire logic relay_drive;
  wire logic [7:0] n_pulse;
  wire logic [7:0] hi_ticks;
  wire logic [7:0] gap_ticks;
  logic [31:0] d;
  logic e;
  int tests_run = 0;
  int n_mismatch = 0;
  int c;
  int wt;
  relay_output_pulser #(.MAINS_HZ(50), .PEND_W(8)) relay_output_pulser_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cycle_tick(cycle_tick), .setpoint_op(setpoint_op),
    .energy_quantum(energy_quantum), .relay_drive(relay_drive));
  coil_model coil_model_inst (.pclk(pclk), .presetn(presetn), .cycle_tick(cycle_tick),
    .relay_drive(relay_drive), .n_pulse(n_pulse), .hi_ticks(hi_ticks), .gap_ticks(gap_ticks));
  always #4 pclk = ~pclk;
  // mains tick shortened to every 8 clocks to keep pulses brief
  always @(posedge pclk) begin
    tcnt <= tcnt + 3'h1;
    cycle_tick <= (tcnt == 3'h7);
  end
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk_reg(input logic [7:0] a, input logic [31:0] w, input int x);
    xfer(1'b1, a, w);
    xfer(1'b0, a, 32'h0);
    `CHK("register", x, d)
  endtask
  task automatic wait_idle;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 300; i++) begin
      xfer(1'b0, OFS_STATUS, 32'h0);
      if (d[STAT_BUSY_BIT] === 1'b0 && d[15:8] === 8'h00) break;
    end
  endtask
  task automatic qp(input int b);
    energy_quantum <= 6'h01 << b;
    @(posedge pclk);
    energy_quantum <= 6'h00;
    @(posedge pclk);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    xfer(1'b0, OFS_CTRL, 32'h0);
    `CHK("ctrl", 0, d)
    xfer(1'b0, OFS_WIDTH, 32'h0);
    `CHK("width", 100, d)
    xfer(1'b0, OFS_WEIGHT, 32'h0);
    `CHK("weight", 10, d)
    `CHK("drive", 0, relay_drive)
    xfer(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 1, e)
    xfer(1'b0, 8'h02, 32'h0);
    `CHK("unaligned", 1, e)
    xfer(1'b0, OFS_CMD, 32'h0);
    `CHK("cmd read", 0, d)
    $display("test defaults done");
    for (int p = 0; p < 2; p++) begin
      xfer(1'b1, OFS_CTRL, p << 2);
      setpoint_op <= 1'b1;
      repeat (3) @(posedge pclk);
      `CHK("follow on", p == 0, relay_drive)
      setpoint_op <= 1'b0;
      repeat (3) @(posedge pclk);
      `CHK("follow off", p, relay_drive)
    end
    $display("test follow done");
    xfer(1'b1, OFS_CTRL, 32'h1);
    setpoint_op <= 1'b1;
    repeat (2) @(posedge pclk);
    setpoint_op <= 1'b0;
    repeat (3) @(posedge pclk);
    `CHK("hold", 1, relay_drive)
    xfer(1'b1, OFS_CMD, 32'h2);
    repeat (2) @(posedge pclk);
    `CHK("clear", 0, relay_drive)
    xfer(1'b1, OFS_CMD, 32'h1);
    repeat (2) @(posedge pclk);
    `CHK("remote set", 1, relay_drive)
    xfer(1'b1, OFS_CMD, 32'h2);
    $display("test hold done");
    chk_reg(OFS_WIDTH, 2000, 1000);
    chk_reg(OFS_WIDTH, 5, 20);
    chk_reg(OFS_WEIGHT, 0, 1);
    chk_reg(OFS_WEIGHT, 20000, 10000);
    $display("test limits done");
    wt = (30 * 50 + 999) / 1000;
    chk_reg(OFS_WIDTH, 30, 30);
    xfer(1'b1, OFS_CTRL, 32'h2);
    c = n_pulse;
    // second command lands mid-pulse and must queue
    xfer(1'b1, OFS_CMD, 32'h4);
    xfer(1'b1, OFS_CMD, 32'h4);
    wait_idle();
    `CHK("pulses", c + 2, n_pulse)
    `CHK("width ticks", wt, hi_ticks)
    `CHK("pause ticks", wt, gap_ticks)
    `CHK("idle", 0, relay_drive)
    $display("test timed done");
    xfer(1'b1, OFS_CTRL, 32'h3);
    xfer(1'b1, OFS_CMD, 32'h4);
    wait_idle();
    `CHK("toggle on", 1, relay_drive)
    repeat (40) @(posedge pclk);
    `CHK("toggle held", 1, relay_drive)
    xfer(1'b1, OFS_CMD, 32'h4);
    wait_idle();
    `CHK("toggle off", 0, relay_drive)
    $display("test transition done");
    chk_reg(OFS_WEIGHT, 2, 2);
    xfer(1'b1, OFS_CTRL, 32'h2);
    for (int s = 1; s <= 6; s++) begin
      xfer(1'b1, OFS_CTRL, 2 | (s << 4));
      c = n_pulse;
      qp(s % 6);
      qp(s % 6);
      qp(s - 1);
      qp(s - 1);
      wait_idle();
      `CHK("energy", c + 1, n_pulse)
    end
    $display("test energy done");
    conclude();
  end
endmodule
